// ### rtl/adcc_top.sv
// Overview of operation
// - In hardware trigger mode, a timekeeper match starts a conversion.
// - Match triggers regardless of the timekeeper's own interrupt enable.
// - Hardware trigger works in run, wait, low-power and stop3 states.
// - Control write aborts running conversion, starts new in software trigger mode unless channel is all ones.
// - Compare off: completion flag bit 7 set after every conversion.
// - Compare on: completion flag set only when compare condition holds.
// - Flag cleared by control write or by reading low result.
// - Interrupt asserted when flag is set while enable bit 6 is high.
// - Single mode: one conversion per write or per hardware trigger.
// - Continuous mode: back-to-back conversions after write or trigger.
// - Channel field bits 4:0 select inputs, references, reserved code.
// - All-ones channel powers converter off and isolates input.
// - Stopping continuous mode with all ones runs no extra conversion.
// - Single mode returns converter to low-power idle after completion.
// - Up to 28 external analog input channels selectable.
// - Results right-justified unsigned in 12, 10 or 8 bits.
// - Automatic compare, less-than or greater-or-equal, flagged with interrupt.
// - Trigger-select bit picks software write or hardware trigger start.
// - Active status bit set at start, cleared on single-mode completion or on an abort that starts no new conversion.
// - Results updated each completion unless compare enabled and unmet, or locked by a high-byte read.
`timescale 1ns/10ps
`default_nettype none
module adcc_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Timekeeper match strobe
  input wire logic hardware_trigger_in,
  // Analog converter core
  output adcc_pkg::adcc_conv_req_t conv_req,
  input wire adcc_pkg::adcc_conv_rsp_t conv_rsp,
  // Interrupt
  output logic completion_irq
);
  // ==========================================
  // Registers
  logic completion_flag;
  logic completion_irq_enable;
  logic continuous_mode;
  logic [4:0] channel_select;
  logic trigger_select;
  logic compare_enable;
  logic compare_greater_equal;
  logic [3:0] compare_value_high;
  logic [7:0] compare_value_low;
  logic [1:0] mode;
  logic [11:0] result;
  logic result_lock;
  adcc_pkg::adcc_state_t state;
  logic trig_s1;
  logic trig_s2;
  logic trig_s3;
  // ==========================================
  // Combinational
  logic wr_hit;
  logic rd_hit;
  logic wr_ctl;
  logic rd_rlo;
  logic rd_rhi;
  logic trig_edge;
  logic done_ok;
  logic [11:0] res;
  logic [11:0] cv;
  logic cmp_true;
  logic hit;
  logic [4:0] next_ch;
  logic next_flag;
  logic next_ien;
  adcc_pkg::adcc_state_t next_state;
  logic next_start;
  logic next_abort;
  // ==========================================
  // Bus decode
  // A write lands only on the low byte lane; upper lanes hold nothing.
  assign wr_hit = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign rd_hit = avs_read && !avs_waitrequest;
  assign wr_ctl = wr_hit && (avs_address == adcc_pkg::ADDR_CTL);
  assign rd_rlo = rd_hit && (avs_address == adcc_pkg::ADDR_RLO);
  assign rd_rhi = rd_hit && (avs_address == adcc_pkg::ADDR_RHI);

  // ==========================================
  // Wait-state generator: one wait cycle, then the access completes
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      avs_waitrequest <= 1'b1;
    else if ((avs_read || avs_write) && avs_waitrequest)
      avs_waitrequest <= 1'b0;
    else
      avs_waitrequest <= 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read && avs_waitrequest)
    begin
      avs_readdata <= 32'h0000_0000;
      unique case (avs_address)
        adcc_pkg::ADDR_CTL:
          avs_readdata[7:0] <= {completion_flag, completion_irq_enable,
                                continuous_mode, channel_select};
        adcc_pkg::ADDR_CTL2:
          avs_readdata[7:0] <= {state == adcc_pkg::ST_CONV, trigger_select,
                                compare_enable, compare_greater_equal, 4'h0};
        adcc_pkg::ADDR_RHI:
          avs_readdata[3:0] <= result[11:8];
        adcc_pkg::ADDR_RLO:
          avs_readdata[7:0] <= result[7:0];
        adcc_pkg::ADDR_CVH:
          avs_readdata[3:0] <= compare_value_high;
        adcc_pkg::ADDR_CVL:
          avs_readdata[7:0] <= compare_value_low;
        adcc_pkg::ADDR_CFG:
          avs_readdata[3:2] <= mode;
        default:
          avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================
  // Software registers
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      completion_irq_enable <= 1'b0;
      continuous_mode <= 1'b0;
      channel_select <= adcc_pkg::CH_RST;
    end
    else if (wr_ctl)
    begin
      completion_irq_enable <= avs_writedata[adcc_pkg::CTL_IEN];
      continuous_mode <= avs_writedata[adcc_pkg::CTL_CONT];
      channel_select <= next_ch;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      trigger_select <= 1'b0;
      compare_enable <= 1'b0;
      compare_greater_equal <= 1'b0;
      compare_value_high <= 4'h0;
      compare_value_low <= 8'h00;
      mode <= adcc_pkg::MODE_RST;
    end
    else if (wr_hit)
    begin
      unique case (avs_address)
        adcc_pkg::ADDR_CTL2:
        begin
          trigger_select <= avs_writedata[adcc_pkg::CTL2_TRIG];
          compare_enable <= avs_writedata[adcc_pkg::CTL2_CMPEN];
          compare_greater_equal <= avs_writedata[adcc_pkg::CTL2_CMPGE];
        end
        adcc_pkg::ADDR_CVH:
          compare_value_high <= avs_writedata[3:0];
        adcc_pkg::ADDR_CVL:
          compare_value_low <= avs_writedata[7:0];
        adcc_pkg::ADDR_CFG:
          mode <= avs_writedata[adcc_pkg::CFG_MODE_LSB +: 2];
        default:
          mode <= mode;
      endcase
    end
  end

  // ==========================================
  // Hardware trigger synchroniser and edge detect
  // Match strobe arrives in any power state; only a rising edge counts.
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      trig_s3 <= 1'b0;
    end
    else
    begin
      trig_s1 <= hardware_trigger_in;
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
    end
  end

  assign trig_edge = trig_s2 && !trig_s3;
  // ==========================================
  // Result formatting and compare
  always_comb
  begin
    unique case (mode)
      adcc_pkg::MODE_12:
      begin
        res = conv_rsp.data;
        cv = {compare_value_high, compare_value_low};
      end
      adcc_pkg::MODE_10:
      begin
        res = {2'h0, conv_rsp.data[11:2]};
        cv = {2'h0, compare_value_high[1:0], compare_value_low};
      end
      default:
      begin
        res = {4'h0, conv_rsp.data[11:4]};
        cv = {4'h0, compare_value_low};
      end
    endcase
  end

  assign cmp_true = compare_greater_equal ? (res >= cv) : (res < cv);
  // A completion in the same cycle as a control write belongs to the aborted conversion.
  assign done_ok = (state == adcc_pkg::ST_CONV) && conv_rsp.done && !wr_ctl;
  assign hit = done_ok && (!compare_enable || cmp_true);

  // ==========================================
  // Sequencer
  assign next_ch = wr_ctl ? avs_writedata[4:0] : channel_select;
  always_comb
  begin
    next_state = state;
    next_start = 1'b0;
    next_abort = 1'b0;
    if (wr_ctl)
    begin
      next_abort = (state == adcc_pkg::ST_CONV);
      next_state = adcc_pkg::ST_IDLE;
      if (next_ch != adcc_pkg::CH_OFF && !trigger_select)
      begin
        next_start = 1'b1;
        next_state = adcc_pkg::ST_CONV;
      end
    end
    else if (state == adcc_pkg::ST_IDLE)
    begin
      if (trigger_select && trig_edge && channel_select != adcc_pkg::CH_OFF)
      begin
        next_start = 1'b1;
        next_state = adcc_pkg::ST_CONV;
      end
    end
    else if (done_ok)
    begin
      if (continuous_mode && channel_select != adcc_pkg::CH_OFF)
        next_start = 1'b1;
      else
        next_state = adcc_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      state <= adcc_pkg::ST_IDLE;
    else
      state <= next_state;
  end

  // Converter is powered only while a conversion runs, so idle is low power.
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      conv_req <= '0;
    else
    begin
      conv_req.start <= next_start;
      conv_req.abort <= next_abort;
      conv_req.power <= (next_state == adcc_pkg::ST_CONV);
      conv_req.channel <= next_ch;
      conv_req.mode <= (wr_hit && avs_address == adcc_pkg::ADDR_CFG) ?
                       avs_writedata[adcc_pkg::CFG_MODE_LSB +: 2] : mode;
    end
  end

  // ==========================================
  // Completion flag, interrupt and results
  // Set beats clear, so a completion racing a low-result read is never lost.
  always_comb
  begin
    if (hit)
      next_flag = 1'b1;
    else if (wr_ctl || rd_rlo)
      next_flag = 1'b0;
    else
      next_flag = completion_flag;
  end

  assign next_ien = wr_ctl ? avs_writedata[adcc_pkg::CTL_IEN] : completion_irq_enable;
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      completion_flag <= 1'b0;
      completion_irq <= 1'b0;
    end
    else
    begin
      completion_flag <= next_flag;
      completion_irq <= next_flag && next_ien;
    end
  end

  // Reading the high byte locks the pair until the low byte is read.
  // In 8-bit mode there is no high byte worth locking.
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      result_lock <= 1'b0;
    else if (rd_rhi && mode != adcc_pkg::MODE_8)
      result_lock <= 1'b1;
    else if (rd_rlo)
      result_lock <= 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      result <= 12'h000;
    else if (hit && !result_lock)
      result <= res;
  end
endmodule : adcc_top
`default_nettype wire

// ### rtl/adcc_pkg.sv
package adcc_pkg;
  // ==========================================
  // Register byte addresses
  localparam logic [4:0] ADDR_CTL = 5'h00;
  localparam logic [4:0] ADDR_CTL2 = 5'h04;
  localparam logic [4:0] ADDR_RHI = 5'h08;
  localparam logic [4:0] ADDR_RLO = 5'h0C;
  localparam logic [4:0] ADDR_CVH = 5'h10;
  localparam logic [4:0] ADDR_CVL = 5'h14;
  localparam logic [4:0] ADDR_CFG = 5'h18;
  // ==========================================
  // Field positions
  localparam int CTL_FLAG = 7;
  localparam int CTL_IEN = 6;
  localparam int CTL_CONT = 5;
  localparam int CTL2_ACTIVE = 7;
  localparam int CTL2_TRIG = 6;
  localparam int CTL2_CMPEN = 5;
  localparam int CTL2_CMPGE = 4;
  localparam int CFG_MODE_LSB = 2;
  // ==========================================
  // Codes and reset values
  localparam logic [4:0] CH_OFF = 5'h1F;
  localparam logic [4:0] CH_RESERVED = 5'h1C;
  localparam logic [1:0] MODE_8 = 2'h0;
  localparam logic [1:0] MODE_12 = 2'h1;
  localparam logic [1:0] MODE_10 = 2'h2;
  localparam logic [4:0] CH_RST = 5'h1F;
  localparam logic [1:0] MODE_RST = 2'h0;
  // ==========================================
  // Types
  typedef enum logic {ST_IDLE, ST_CONV} adcc_state_t;
  typedef struct packed {
    logic start;
    logic abort;
    logic power;
    logic [4:0] channel;
    logic [1:0] mode;
  } adcc_conv_req_t;
  typedef struct packed {
    logic done;
    logic [11:0] data;
  } adcc_conv_rsp_t;
endpackage : adcc_pkg

// ### tb/adcc_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module adcc_assertions (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Register bus
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Converter and interrupt
  input wire logic hardware_trigger_in,
  input wire adcc_pkg::adcc_conv_req_t conv_req,
  input wire adcc_pkg::adcc_conv_rsp_t conv_rsp,
  input wire logic completion_irq
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  logic ctl_wr;
  assign ctl_wr = avs_write && !avs_waitrequest && avs_address == adcc_pkg::ADDR_CTL
    && avs_byteenable[0];
  // ==========================================
  // Assertions
  AST_OFF_NO_START:
    assert property (conv_req.start |-> conv_req.channel != adcc_pkg::CH_OFF)
    else $error("start issued with converter off");
  AST_STOP_NO_EXTRA:
    assert property (ctl_wr && avs_writedata[4:0] == adcc_pkg::CH_OFF |=> (!conv_req.start)[*3])
    else $error("conversion started after switch-off write");
  AST_START_POWER:
    assert property (conv_req.start |=> conv_req.power || conv_req.abort)
    else $error("converter not powered after start");
  AST_ONE_START:
    assert property (conv_req.start |=> !conv_req.start || conv_req.abort)
    else $error("start pulse longer than one cycle");
  AST_IRQ_CAUSE:
    assert property ($rose(completion_irq) |-> $past(conv_rsp.done))
    else $error("interrupt raised without a completion");
  AST_WRITE_CLEARS:
    assert property (ctl_wr |=> !completion_irq)
    else $error("control write left interrupt pending");
  AST_WAIT_ONE:
    assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_POWER_DROP:
    assert property ($fell(conv_req.power) |-> conv_req.abort || $past(conv_rsp.done))
    else $error("power dropped without completion or abort");
  // ==========================================
  // Coverage
  COV_START: cover property (conv_req.start);
  COV_IRQ: cover property ($rose(completion_irq));
  COV_ABORT: cover property (conv_req.abort);
endmodule : adcc_assertions
bind adcc_top adcc_assertions adcc_assertions_inst (.ref_clk(ref_clk), .rstn(rstn),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .hardware_trigger_in(hardware_trigger_in), .conv_req(conv_req), .conv_rsp(conv_rsp),
  .completion_irq(completion_irq));
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic ref_clk, rstn, avs_read, avs_write, avs_waitrequest, hardware_trigger_in;
  logic completion_irq, hit;
  logic [4:0] avs_address, ch_exp;
  logic [1:0] md_exp;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  adcc_pkg::adcc_conv_req_t conv_req;
  adcc_pkg::adcc_conv_rsp_t conv_rsp = '0;
  logic [11:0] dval, e, last;
  logic [1:0] md [3] = '{adcc_pkg::MODE_12, adcc_pkg::MODE_10, adcc_pkg::MODE_8};
  int sh [3] = '{0, 2, 4};
  logic [31:0] q [$];
  int checks = 0, miscompares = 0, nst = 0, cnt = 0, nab = 0, n0, i;
  adcc_top adcc_top_inst (.ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .hardware_trigger_in(hardware_trigger_in),
    .conv_req(conv_req), .conv_rsp(conv_rsp), .completion_irq(completion_irq));
  // ==========================================
  // Tasks
  task chk(input string n, input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  task end_sim;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  // Ends with an idle edge so a following request never re-drives in the same step
  task wr(input logic [4:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= 1'b1;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask : wr
  task rd(input logic [4:0] a, input logic [7:0] x);
    q.push_back({24'h0, x});
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask : rd
  task wdone;
    repeat (100) if (conv_rsp.done !== 1'b1) @(posedge ref_clk);
    @(posedge ref_clk);
  endtask : wdone
  // ==========================================
  // Clock, read monitor, converter model, watchdog
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
      chk("readdata", avs_readdata, q.pop_front());
  // Idle data lines carry the inverted value so a stale result is never mistaken for a fresh one
  always @(posedge ref_clk)
  begin
    if (conv_req.start === 1'b1)
    begin
      chk("channel", {27'h0, conv_req.channel}, {27'h0, ch_exp});
      chk("mode", {30'h0, conv_req.mode}, {30'h0, md_exp});
      chk("power", {31'h0, conv_req.power}, 32'h1);
      nst <= nst + 1;
      cnt <= 4;
    end
    else if (conv_req.abort === 1'b1)
      cnt <= 0;
    else if (cnt > 0)
      cnt <= cnt - 1;
    nab <= nab + ((conv_req.abort === 1'b1) ? 1 : 0);
    conv_rsp.done <= cnt == 1 && conv_req.start !== 1'b1 && conv_req.abort !== 1'b1;
    conv_rsp.data <= (cnt == 1) ? dval : ~dval;
  end
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    end_sim();
  end
  // ==========================================
  // Main sequence
  initial
  begin
    {rstn, avs_read, avs_write, avs_address, avs_writedata, hardware_trigger_in} = '0;
    avs_byteenable = 4'hF;
    dval = 12'h000;
    ch_exp = 5'h00;
    void'($urandom(32'h3715));
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    avs_byteenable <= 4'hE;
    wr(adcc_pkg::ADDR_CTL, 8'h05);
    avs_byteenable <= 4'hF;
    wr(5'h1C, 8'hFF);
    rd(adcc_pkg::ADDR_CTL, 8'h1F);
    rd(5'h1C, 8'h00);
    for (i = 0; i < 31; i++)
    begin
      dval = 12'($urandom());
      ch_exp = i[4:0];
      md_exp = md[i % 3];
      wr(adcc_pkg::ADDR_CFG, {4'h0, md[i % 3], 2'b00});
      wr(adcc_pkg::ADDR_CTL, {3'b010, i[4:0]});
      wdone();
      chk("irq", {31'h0, completion_irq}, 32'h1);
      chk("power", {31'h0, conv_req.power}, 32'h0);
      e = dval >> sh[i % 3];
      rd(adcc_pkg::ADDR_CTL, {3'b110, i[4:0]});
      rd(adcc_pkg::ADDR_CTL2, 8'h00);
      rd(adcc_pkg::ADDR_RHI, {4'h0, e[11:8]});
      rd(adcc_pkg::ADDR_RLO, e[7:0]);
      rd(adcc_pkg::ADDR_CTL, {3'b010, i[4:0]});
      chk("irq", {31'h0, completion_irq}, 32'h0);
    end
    last = dval;
    ch_exp = 5'h01;
    wr(adcc_pkg::ADDR_CFG, 8'h04);
    wr(adcc_pkg::ADDR_CVH, 8'h08);
    wr(adcc_pkg::ADDR_CVL, 8'h00);
    for (i = 0; i < 4; i++)
    begin
      dval = i[1] ? 12'h800 : 12'h7FF;
      hit = i[0] ? dval >= 12'h800 : dval < 12'h800;
      wr(adcc_pkg::ADDR_CTL2, {3'b001, i[0], 4'h0});
      wr(adcc_pkg::ADDR_CTL, 8'h01);
      wdone();
      if (hit)
        last = dval;
      rd(adcc_pkg::ADDR_CTL, {hit, 7'h01});
      rd(adcc_pkg::ADDR_RHI, {4'h0, last[11:8]});
      rd(adcc_pkg::ADDR_RLO, last[7:0]);
    end
    wr(adcc_pkg::ADDR_CTL2, 8'h00);
    ch_exp = 5'h02;
    n0 = nst;
    wr(adcc_pkg::ADDR_CTL, 8'h22);
    repeat (40) @(posedge ref_clk);
    chk("continuous", 32'(nst - n0 >= 5), 32'h1);
    rd(adcc_pkg::ADDR_CTL2, 8'h80);
    wr(adcc_pkg::ADDR_CTL, 8'h1F);
    n0 = nst;
    repeat (20) @(posedge ref_clk);
    chk("stopped", nst, n0);
    chk("abort", nab, 1);
    chk("off power", {31'h0, conv_req.power}, 32'h0);
    ch_exp = 5'h03;
    wr(adcc_pkg::ADDR_CTL2, 8'h40);
    wr(adcc_pkg::ADDR_CTL, 8'h43);
    repeat (10) @(posedge ref_clk);
    chk("hw idle", nst, n0);
    for (i = 0; i < 2; i++)
    begin
      hardware_trigger_in <= 1'b1;
      repeat (3 + 6 * i) @(posedge ref_clk);
      hardware_trigger_in <= 1'b0;
      repeat (20) @(posedge ref_clk);
      chk("hw starts", nst, n0 + i + 1);
    end
    rd(adcc_pkg::ADDR_CTL, 8'hC3);
    chk("irq", {31'h0, completion_irq}, 32'h1);
    end_sim();
  end
endmodule : tb
`default_nettype wire
